// ===== core/ocf_consts.vh
// Purpose: Constants for the overcurrent fault response and bus config block
// Assumes: 40 MHz clock, command codes used as register offsets
// Notes:   Reset values are plain defaults
`ifndef OCF_CONSTS_VH
`define OCF_CONSTS_VH

// Command codes (register offsets)
`define OCF_CMD_BUS_CFG      8'hc9
`define OCF_CMD_FAST_RESP    8'hca
`define OCF_CMD_AVG_LIMIT    8'hd0
`define OCF_CMD_FAST_LIMIT   8'hd1

// Field positions of the bus and pin configuration word
`define OCF_PG_POL_BIT       39
`define OCF_CTL_POL_BIT      32
`define OCF_BASE_HI          31
`define OCF_BASE_LO          24
`define OCF_OFFS_HI          23
`define OCF_OFFS_LO          17
`define OCF_OFFS_EN_BIT      16

// Field positions of the fast overcurrent response byte
`define OCF_RESP_HI          7
`define OCF_RESP_LO          6
`define OCF_RETRY_HI         5
`define OCF_RETRY_LO         3
`define OCF_DELAY_HI         2
`define OCF_DELAY_LO         0

// Response and retry codes
`define OCF_RESP_IGNORE      2'h0
`define OCF_RESP_SHUTDOWN    2'h3
`define OCF_RETRY_NONE       3'h0
`define OCF_RETRY_FOREVER    3'h7

// Reset values
`define OCF_BUS_CFG_RST      40'h81_4000_0000
`define OCF_FAST_RESP_RST    8'h00
`define OCF_AVG_LIMIT_RST    16'h0000
`define OCF_FAST_LIMIT_RST   16'hffff

// Delay unit multipliers in milliseconds (unit codes 0..3)
`define OCF_UNIT_MS_0        16'h0001
`define OCF_UNIT_MS_1        16'h0004
`define OCF_UNIT_MS_2        16'h0010
`define OCF_UNIT_MS_3        16'h0100

// Timing: one millisecond, expressed in ns, and the clock period
`define OCF_UNIT_TIME_NS     1000000
`define OCF_CLK_PERIOD_NS    25
`define OCF_MS_CYCLES        (`OCF_UNIT_TIME_NS / `OCF_CLK_PERIOD_NS)

`endif

// ===== core/ocf_delay_timer.v
// Purpose: Counts a number of delay units of 1, 4, 16 or 256 ms
// Assumes: start is a one-cycle pulse from the same clock
// Notes:   done pulses once when the programmed time has elapsed
`include "ocf_consts.vh"
`default_nettype none

module ocf_delay_timer #(
  parameter MS_CYCLES = `OCF_MS_CYCLES
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Control
  input  wire        start,
  input  wire        cancel,
  input  wire [2:0]  delay_exp,
  input  wire [1:0]  unit_sel,
  // Status
  output reg         done
);

  reg  [15:0] pre_reg;
  reg  [15:0] ms_reg;
  reg  [15:0] target_reg;
  reg         busy_reg;
  wire [15:0] unit_ms;
  wire        ms_tick;

  // Milliseconds per delay unit
  assign unit_ms = (unit_sel == 2'h0) ? `OCF_UNIT_MS_0 :
                   (unit_sel == 2'h1) ? `OCF_UNIT_MS_1 :
                   (unit_sel == 2'h2) ? `OCF_UNIT_MS_2 : `OCF_UNIT_MS_3;
  assign ms_tick = (pre_reg == MS_CYCLES[15:0] - 16'h0001);

  // Prescaler, millisecond count and end detection
  always @(posedge clock) begin
    done <= 1'b0;
    if (rst || cancel) begin
      pre_reg  <= 16'h0000;
      ms_reg   <= 16'h0000;
      busy_reg <= 1'b0;
      target_reg <= 16'h0000;
    end else if (start) begin
      pre_reg    <= 16'h0000;
      ms_reg     <= 16'h0000;
      busy_reg   <= 1'b1;
      target_reg <= unit_ms << delay_exp; // RULE_14 RULE_19
    end else if (busy_reg) begin
      pre_reg <= ms_tick ? 16'h0000 : pre_reg + 16'h0001;
      if (ms_tick) begin
        ms_reg <= ms_reg + 16'h0001;
        if (ms_reg + 16'h0001 == target_reg) begin
          busy_reg <= 1'b0;
          done     <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== core/ocf_fault_response.v
// Purpose: Bus address config, pin polarity and fast overcurrent response
// Assumes: Command port and current reading come from same-clock logic
// Notes:   Pins are synchronised by two flip-flops before use
//
// Functional notes
// RULE_01: Base address is the top byte; bus address is base plus offset.
// RULE_02: Offset source disabled means the programmed seven-bit offset applies.
// RULE_03: Offset enable bit one takes the resistor strap offset instead.
// RULE_04: Power-good pin active high when its polarity bit is one.
// RULE_05: Control pin read active high when its polarity bit is one.
// RULE_06: Host keeps fault, power-good and enable pin selections distinct.
// RULE_07: Host keeps the I2C and PMBus addresses different.
// RULE_08: Any fast overcurrent sets the status bit and notifies the host.
// RULE_09: Code 00 keeps running forever with constant-current limiting.
// RULE_10: Code 11 limits for the delay, then applies the retry setting.
// RULE_11: Retry 000 keeps the output off until the fault is cleared.
// RULE_12: Retry 001 to 110 tries that many restarts, then latches off.
// RULE_13: Retry 111 restarts without limit until off, bias loss or fault.
// RULE_14: Delay field gives two to the field value time units.
// RULE_15: Same delay count for fault hold time and restart spacing.
// RULE_16: The time unit comes from the separate fault timing register.
// RULE_17: Sixteen-bit readable and writable averaged overcurrent threshold.
// RULE_18: Sixteen-bit unsigned fast overcurrent threshold, readable back.
// RULE_19: Two-bit unit code selects 1, 4, 16 or 256 ms.
// RULE_20: Current above the fast threshold declares the fault, starts timer.
`include "ocf_consts.vh"
`default_nettype none

module ocf_fault_response #(
  parameter MS_CYCLES = `OCF_MS_CYCLES
) (
  // Clock and reset
  input  wire        clock,
  input  wire        rst,
  // Command port
  input  wire        cmd_valid,
  input  wire        cmd_write,
  input  wire [7:0]  cmd_code,
  input  wire [39:0] cmd_wdata,
  output reg         rsp_valid,
  output reg         rsp_error,
  output reg  [39:0] rsp_rdata,
  // Pins
  input  wire        on_off_pin,
  input  wire        bias_ok_pin,
  input  wire [6:0]  offset_strap,
  output reg         power_good_pin,
  // Regulator and system logic
  input  wire        operation_on,
  input  wire        other_fault,
  input  wire        fault_clear,
  input  wire [15:0] measured_current,
  input  wire [1:0]  current_delay_unit,
  output reg         output_enable,
  output reg         current_limit_en,
  output reg         fast_oc_status,
  output reg         host_notify,
  output reg  [7:0]  pmbus_address
);

  //////////////////////////////////////////////////////////////////////////
  // States
  localparam [4:0] ST_OFF     = 5'b00001;
  localparam [4:0] ST_RUN     = 5'b00010;
  localparam [4:0] ST_LIMIT   = 5'b00100;
  localparam [4:0] ST_WAIT    = 5'b01000;
  localparam [4:0] ST_LATCHED = 5'b10000;

  //////////////////////////////////////////////////////////////////////////
  // Declarations
  reg  [39:0] bus_and_pin_config_reg;
  reg  [7:0]  fast_overcurrent_response_reg;
  reg  [15:0] average_overcurrent_limit_reg;
  reg  [15:0] fast_overcurrent_limit_reg;
  reg  [4:0]  state_reg;
  reg  [4:0]  state_next;
  reg  [2:0]  attempts_reg;
  reg  [2:0]  attempts_next;
  reg         timer_start;
  reg         over_prev_reg;
  reg         on_off_meta_reg;
  reg         on_off_sync_reg;
  reg         bias_meta_reg;
  reg         bias_sync_reg;
  reg  [6:0]  strap_meta_reg;
  reg  [6:0]  strap_sync_reg;
  wire        timer_done;
  wire        control_on;
  wire        run_allowed;
  wire        over_limit;
  wire        fault_event;
  wire [1:0]  resp_code;
  wire [2:0]  retry_code;
  wire [2:0]  delay_exp;
  wire [6:0]  addr_offset;
  wire        power_good;

  //////////////////////////////////////////////////////////////////////////
  // Helper functions

  // True when the response code asks for hold, shut down and retry
  function is_shutdown;
    input [1:0] code;
    begin
      is_shutdown = (code != `OCF_RESP_IGNORE);
    end
  endfunction

  // True when another restart may still be attempted
  function retry_left;
    input [2:0] setting;
    input [2:0] used;
    begin
      if (setting == `OCF_RETRY_FOREVER)
        retry_left = 1'b1; // RULE_13
      else
        retry_left = (used < setting); // RULE_11 RULE_12
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  always @(posedge clock) begin
    if (rst) begin
      on_off_meta_reg <= 1'b0;
      on_off_sync_reg <= 1'b0;
      bias_meta_reg   <= 1'b0;
      bias_sync_reg   <= 1'b0;
      strap_meta_reg  <= 7'h00;
      strap_sync_reg  <= 7'h00;
    end else begin
      on_off_meta_reg <= on_off_pin;
      on_off_sync_reg <= on_off_meta_reg;
      bias_meta_reg   <= bias_ok_pin;
      bias_sync_reg   <= bias_meta_reg;
      strap_meta_reg  <= offset_strap;
      strap_sync_reg  <= strap_meta_reg;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Field decode
  assign resp_code  = fast_overcurrent_response_reg[`OCF_RESP_HI:`OCF_RESP_LO];
  assign retry_code = fast_overcurrent_response_reg[`OCF_RETRY_HI:`OCF_RETRY_LO];
  assign delay_exp  = fast_overcurrent_response_reg[`OCF_DELAY_HI:`OCF_DELAY_LO];

  // Address offset source
  assign addr_offset = bus_and_pin_config_reg[`OCF_OFFS_EN_BIT] ?
                       strap_sync_reg : // RULE_03
                       bus_and_pin_config_reg[`OCF_OFFS_HI:`OCF_OFFS_LO]; // RULE_02

  // Control pin polarity and run permission
  assign control_on  = bus_and_pin_config_reg[`OCF_CTL_POL_BIT] ?
                       on_off_sync_reg : ~on_off_sync_reg; // RULE_05
  assign run_allowed = control_on & operation_on & bias_sync_reg &
                       ~other_fault;

  // Fast overcurrent comparison
  assign over_limit  = (measured_current > fast_overcurrent_limit_reg); // RULE_20
  assign fault_event = over_limit & ~over_prev_reg &
                       (state_reg == ST_RUN);

  // Output is good while running and not being held at the limit
  assign power_good  = (state_reg == ST_RUN) & ~over_limit;

  //////////////////////////////////////////////////////////////////////////
  // Delay timer, shared by fault hold time and restart spacing
  ocf_delay_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) u_timer (
    .clock     (clock),
    .rst       (rst),
    .start     (timer_start),
    .cancel    (~run_allowed),
    .delay_exp (delay_exp), // RULE_15
    .unit_sel  (current_delay_unit), // RULE_16
    .done      (timer_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // Register writes
  always @(posedge clock) begin
    if (rst) begin
      bus_and_pin_config_reg        <= `OCF_BUS_CFG_RST;
      fast_overcurrent_response_reg <= `OCF_FAST_RESP_RST;
      average_overcurrent_limit_reg <= `OCF_AVG_LIMIT_RST;
      fast_overcurrent_limit_reg    <= `OCF_FAST_LIMIT_RST;
    end else if (cmd_valid && cmd_write) begin
      case (cmd_code)
        `OCF_CMD_BUS_CFG: begin
          bus_and_pin_config_reg <= cmd_wdata; // RULE_01
        end
        `OCF_CMD_FAST_RESP: begin
          fast_overcurrent_response_reg <= cmd_wdata[7:0];
        end
        `OCF_CMD_AVG_LIMIT: begin
          average_overcurrent_limit_reg <= cmd_wdata[15:0]; // RULE_17
        end
        `OCF_CMD_FAST_LIMIT: begin
          fast_overcurrent_limit_reg <= cmd_wdata[15:0]; // RULE_18
        end
        default: begin
          fast_overcurrent_limit_reg <= fast_overcurrent_limit_reg;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register reads and command answer
  always @(posedge clock) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_error <= 1'b0;
      rsp_rdata <= 40'h00_0000_0000;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_error <= 1'b0;
      rsp_rdata <= 40'h00_0000_0000;
      if (cmd_valid) begin
        case (cmd_code)
          `OCF_CMD_BUS_CFG: begin
            rsp_rdata <= bus_and_pin_config_reg;
          end
          `OCF_CMD_FAST_RESP: begin
            rsp_rdata <= {32'h0000_0000, fast_overcurrent_response_reg};
          end
          `OCF_CMD_AVG_LIMIT: begin
            rsp_rdata <= {24'h00_0000, average_overcurrent_limit_reg}; // RULE_17
          end
          `OCF_CMD_FAST_LIMIT: begin
            rsp_rdata <= {24'h00_0000, fast_overcurrent_limit_reg}; // RULE_18
          end
          default: begin
            rsp_error <= 1'b1;
          end
        endcase
      end
      // Writes answer with zero data, only reads return a register
      if (cmd_valid && cmd_write)
        rsp_rdata <= 40'h00_0000_0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Fault response state machine, next state
  always @* begin
    state_next    = state_reg;
    attempts_next = attempts_reg;
    timer_start   = 1'b0;
    case (state_reg)
      ST_OFF: begin
        attempts_next = 3'h0;
        if (run_allowed)
          state_next = ST_RUN;
      end
      ST_RUN: begin
        if (!run_allowed) begin
          state_next = ST_OFF; // RULE_13
        end else if (fault_event && is_shutdown(resp_code)) begin
          state_next  = ST_LIMIT; // RULE_10
          timer_start = 1'b1; // RULE_20
        end
      end
      ST_LIMIT: begin
        if (!run_allowed) begin
          state_next = ST_OFF;
        end else if (timer_done) begin
          if (!over_limit) begin
            state_next = ST_RUN;
          end else if (retry_left(retry_code, attempts_reg)) begin
            state_next  = ST_WAIT; // RULE_10
            timer_start = 1'b1; // RULE_15
          end else begin
            state_next = ST_LATCHED; // RULE_11 RULE_12
          end
        end
      end
      ST_WAIT: begin
        if (!run_allowed) begin
          state_next = ST_OFF;
        end else if (timer_done) begin
          state_next    = ST_RUN;
          if (retry_code != `OCF_RETRY_FOREVER)
            attempts_next = attempts_reg + 3'h1; // RULE_12
        end
      end
      ST_LATCHED: begin
        if (fault_clear)
          state_next = ST_OFF; // RULE_11 RULE_12
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  // Fault response state machine, registers
  always @(posedge clock) begin
    if (rst) begin
      state_reg     <= ST_OFF;
      attempts_reg  <= 3'h0;
      over_prev_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      attempts_reg  <= fault_clear ? 3'h0 : attempts_next;
      over_prev_reg <= over_limit & (state_reg == ST_RUN);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Fault status and host notification, set wins over clear
  always @(posedge clock) begin
    if (rst) begin
      fast_oc_status <= 1'b0;
      host_notify    <= 1'b0;
    end else begin
      host_notify <= fault_event; // RULE_08
      if (fault_event)
        fast_oc_status <= 1'b1; // RULE_08
      else if (fault_clear)
        fast_oc_status <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Output stage, address and pin polarity
  always @(posedge clock) begin
    if (rst) begin
      output_enable    <= 1'b0;
      current_limit_en <= 1'b0;
      power_good_pin   <= 1'b0;
      pmbus_address    <= 8'h00;
    end else begin
      output_enable    <= (state_next == ST_RUN) ||
                          (state_next == ST_LIMIT);
      // Brick-wall limiting while over the limit and still running
      current_limit_en <= over_limit &&
                          ((state_reg == ST_RUN) ||
                           (state_reg == ST_LIMIT)); // RULE_09 RULE_10
      power_good_pin   <= bus_and_pin_config_reg[`OCF_PG_POL_BIT] ?
                          power_good : ~power_good; // RULE_04
      pmbus_address    <= bus_and_pin_config_reg[`OCF_BASE_HI:`OCF_BASE_LO]
                          + {1'b0, addr_offset}; // RULE_01
    end
  end

endmodule
`default_nettype wire

// ===== testbench/ocf_fault_response_test.sv
// Purpose: Self-checking bench for the fault response block
// Assumes: 40 MHz clock, shortened millisecond count
// Notes:   Host model drives the command port
`include "ocf_consts.vh"
`default_nettype none

module ocf_fault_response_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int M = 4;
  // Clock, reset and inputs
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        on_off_pin = 1'b1;
  logic        bias_ok_pin = 1'b1;
  logic [6:0]  offset_strap = 7'h11;
  logic        operation_on = 1'b1;
  logic        other_fault = 1'b0;
  logic        fault_clear = 1'b0;
  logic [15:0] measured_current = 16'h0000;
  logic [1:0]  current_delay_unit = 2'h0;
  // Command wires and outputs
  wire logic        cmd_valid, cmd_write, rsp_valid, rsp_error;
  wire logic [7:0]  cmd_code, pmbus_address;
  wire logic [39:0] cmd_wdata, rsp_rdata;
  wire logic        power_good_pin, output_enable, current_limit_en;
  wire logic        fast_oc_status, host_notify;
  int err_count = 0;
  int check_count = 0;

  always #12.5 clock = ~clock;

  ocf_host_model host (.clock, .cmd_valid, .cmd_write, .cmd_code,
    .cmd_wdata, .rsp_valid, .rsp_error, .rsp_rdata);
  ocf_fault_response #(.MS_CYCLES(M)) dut (.clock, .rst, .cmd_valid,
    .cmd_write, .cmd_code, .cmd_wdata, .rsp_valid, .rsp_error, .rsp_rdata,
    .on_off_pin, .bias_ok_pin, .offset_strap, .power_good_pin,
    .operation_on, .other_fault, .fault_clear, .measured_current,
    .current_delay_unit, .output_enable, .current_limit_en,
    .fast_oc_status, .host_notify, .pmbus_address);

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [39:0] d);
    logic [39:0] q;
    logic e;
    host.xfer(1'b1, c, d, q, e);
  endtask
  task automatic rd(input logic [7:0] c, input logic [39:0] exp);
    logic [39:0] q;
    logic e;
    host.xfer(1'b0, c, 40'h0, q, e);
    check({e, q[38:0]}, {1'b0, exp[38:0]});
    check(q, exp);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic span(input logic lvl, output int n);
    n = 0;
    while (output_enable === lvl && n < 5000) begin
      wait_cyc(1);
      n++;
    end
  endtask
  task automatic recover();
    @(posedge clock);
    measured_current <= 16'h0032;
    bias_ok_pin <= 1'b1;
    fault_clear <= 1'b1;
    wait_cyc(2);
    @(posedge clock);
    fault_clear <= 1'b0;
    wait_cyc(10);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    logic [39:0] q;
    logic e;
    rd(`OCF_CMD_BUS_CFG, 40'h81_4000_0000);
    check(pmbus_address, 8'h40);
    rd(`OCF_CMD_AVG_LIMIT, 40'h0);
    rd(`OCF_CMD_FAST_LIMIT, 40'h00_0000_ffff);
    wr(`OCF_CMD_AVG_LIMIT, 40'h12_3456_789a);
    rd(`OCF_CMD_AVG_LIMIT, 40'h00_0000_789a);
    wr(`OCF_CMD_FAST_LIMIT, 40'h00_0000_beef);
    rd(`OCF_CMD_FAST_LIMIT, 40'h00_0000_beef);
    host.xfer(1'b1, 8'h55, 40'h1, q, e);
    check(e, 1'b1);
    check(q, 40'h00_0000_0000);
    $display("test regs done");
  endtask
  task automatic t_addr();
    wr(`OCF_CMD_BUS_CFG, 40'h81_200a_0000);
    wait_cyc(3);
    check(pmbus_address, 8'h25);
    wr(`OCF_CMD_BUS_CFG, 40'h81_200b_0000);
    wait_cyc(6);
    check(pmbus_address, 8'h31);
    wr(`OCF_CMD_BUS_CFG, 40'h81_f0fe_0000);
    wait_cyc(3);
    check(pmbus_address, 8'h6f);
    $display("test addr done");
  endtask
  task automatic t_pol();
    wr(`OCF_CMD_FAST_LIMIT, 40'h64);
    wr(`OCF_CMD_BUS_CFG, 40'h00_4000_0000);
    wait_cyc(8);
    check({output_enable, power_good_pin}, 2'b01);
    @(posedge clock);
    on_off_pin <= 1'b0;
    wait_cyc(8);
    check({output_enable, power_good_pin}, 2'b10);
    wr(`OCF_CMD_BUS_CFG, 40'h81_4000_0000);
    @(posedge clock);
    on_off_pin <= 1'b1;
    wait_cyc(8);
    check({output_enable, power_good_pin}, 2'b11);
    $display("test polarity done");
  endtask
  task automatic t_ignore();
    int nt;
    int offs;
    wr(`OCF_CMD_FAST_RESP, 40'h0);
    @(posedge clock);
    measured_current <= 16'h0064;
    wait_cyc(6);
    check(fast_oc_status, 1'b0);
    @(posedge clock);
    measured_current <= 16'h0065;
    nt = 0;
    offs = 0;
    repeat (100) begin
      wait_cyc(1);
      nt += (host_notify === 1'b1);
      offs += (output_enable !== 1'b1);
    end
    check({nt[7:0], offs[7:0]}, 16'h0100);
    check({fast_oc_status, current_limit_en}, 2'b11);
    recover();
    check({fast_oc_status, current_limit_en}, 2'b00);
    $display("test ignore done");
  endtask
  task automatic t_delay(input logic [2:0] f, input logic [1:0] u);
    int d;
    int n;
    d = (1 << f) * M * (u == 0 ? 1 : u == 1 ? 4 : u == 2 ? 16 : 256);
    @(posedge clock);
    current_delay_unit <= u;
    wr(`OCF_CMD_FAST_RESP, {32'h0, 2'b11, 3'b111, f});
    @(posedge clock);
    measured_current <= 16'h00c8;
    wait_cyc(1);
    span(1'b1, n);
    check(n >= d && n <= d + 5, 1'b1);
    @(posedge clock);
    measured_current <= 16'h0032;
    span(1'b0, n);
    check(n >= d - 3 && n <= d + 3, 1'b1);
    recover();
    $display("test delay %0d unit %0d done", f, u);
  endtask
  task automatic t_retry(input logic [2:0] r);
    int rises;
    logic last;
    logic [1:0] resp;
    // Codes 01 and 10 act as shutdown and retry too
    resp = (r == 3'h3) ? 2'b01 : (r == 3'h5) ? 2'b10 : 2'b11;
    wr(`OCF_CMD_FAST_RESP, {32'h0, resp, r, 3'b000});
    @(posedge clock);
    current_delay_unit <= 2'h0;
    measured_current <= 16'h00c8;
    rises = 0;
    last = 1'b1;
    repeat (300) begin
      wait_cyc(1);
      rises += (output_enable === 1'b1 && !last);
      last = output_enable;
    end
    if (r == 3'h7) check(rises > 6, 1'b1);
    else check({rises[7:0], output_enable}, {5'h0, r, 1'b0});
    if (r == 3'h7) begin
      @(posedge clock);
      other_fault <= 1'b1;
      wait_cyc(20);
      check(output_enable, 1'b0);
      @(posedge clock);
      other_fault <= 1'b0;
      operation_on <= 1'b0;
      wait_cyc(20);
      check(output_enable, 1'b0);
      @(posedge clock);
      operation_on <= 1'b1;
      bias_ok_pin <= 1'b0;
      wait_cyc(20);
      check(output_enable, 1'b0);
    end
    recover();
    check(output_enable, 1'b1);
    $display("test retry %0d done", r);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Closing and main sequence
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    wait_cyc(3);
    t_regs();
    t_addr();
    t_pol();
    t_ignore();
    t_delay(3'h0, 2'h0);
    t_delay(3'h7, 2'h0);
    t_delay(3'h0, 2'h1);
    t_delay(3'h1, 2'h2);
    t_delay(3'h0, 2'h3);
    for (int r = 0; r < 8; r++) t_retry(3'(r));
    final_report();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (30000) @(posedge clock);
    err_count++;
    final_report();
  end
endmodule

bind ocf_fault_response ocf_monitor mon (.clock, .rst, .cmd_valid,
  .cmd_write, .rsp_valid, .rsp_error, .rsp_rdata, .bias_ok_pin,
  .other_fault, .output_enable, .current_limit_en, .fast_oc_status,
  .fault_clear, .host_notify);

`default_nettype wire

// ===== testbench/ocf_host_model.sv
// Purpose: Host controller issuing configuration commands
// Assumes: Answer is registered on the taking edge and sampled 1 ns after it
// Notes:   Idle code and data lines show inverted last values, write keeps its last value
`default_nettype none

module ocf_host_model (
  // Clock
  input wire logic        clock,
  // Command request
  output var logic        cmd_valid,
  output var logic        cmd_write,
  output var logic [7:0]  cmd_code,
  output var logic [39:0] cmd_wdata,
  // Command answer
  input wire logic        rsp_valid,
  input wire logic        rsp_error,
  input wire logic [39:0] rsp_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code  = 8'h00;
    cmd_wdata = 40'h00_0000_0000;
  end

  // One command; callers keep pin selections and addresses distinct
  task automatic xfer(input logic w, input logic [7:0] c,
                      input logic [39:0] d, output logic [39:0] q,
                      output logic e);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code  <= c;
    cmd_wdata <= d;
    @(posedge clock);
    cmd_valid <= 1'b0;
    cmd_code  <= ~c;
    cmd_wdata <= ~d;
    #1;
    q = (rsp_valid === 1'b1) ? rsp_rdata : 40'hxx_xxxx_xxxx;
    e = rsp_error;
  endtask
endmodule

`default_nettype wire

// ===== testbench/ocf_monitor.sv
// Purpose: Port checker for the fault response block
// Assumes: Attached by bind from the testbench top
// Notes:   Only relations visible at the top ports are checked
`default_nettype none

module ocf_monitor (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Command port
  input wire logic        cmd_valid,
  input wire logic        cmd_write,
  input wire logic        rsp_valid,
  input wire logic        rsp_error,
  input wire logic [39:0] rsp_rdata,
  // Pins and fault link
  input wire logic        bias_ok_pin,
  input wire logic        other_fault,
  input wire logic        output_enable,
  input wire logic        current_limit_en,
  input wire logic        fast_oc_status,
  input wire logic        fault_clear,
  input wire logic        host_notify
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  // Command answers
  property p_rsp_timing; cmd_valid |=> rsp_valid; endproperty
  a_rsp_timing: assert property (p_rsp_timing)
    else $error("answer missing one cycle after request");
  property p_rsp_idle; !cmd_valid |=> !rsp_valid; endproperty
  a_rsp_idle: assert property (p_rsp_idle)
    else $error("answer without request");
  property p_wr_zero; cmd_valid && cmd_write |=> rsp_rdata == 40'h0; endproperty
  a_wr_zero: assert property (p_wr_zero)
    else $error("write answer carries data");

  ////////////////////////////////////////////////////////////////////////////
  // Fault status and notification
  property p_notify; $rose(fast_oc_status) |-> host_notify; endproperty
  a_notify: assert property (p_notify)
    else $error("status set without notification");
  property p_pulse; host_notify |=> !host_notify && fast_oc_status; endproperty
  a_pulse: assert property (p_pulse)
    else $error("notification not a single pulse");
  property p_sticky; fast_oc_status && !fault_clear |=> fast_oc_status;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("status dropped without clear");
  property p_limit; $rose(current_limit_en) |-> output_enable; endproperty
  a_limit: assert property (p_limit)
    else $error("limiting started with output off");

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown causes
  property p_other; other_fault [*4] |-> !output_enable; endproperty
  a_other: assert property (p_other)
    else $error("output on during other fault");
  property p_bias; !bias_ok_pin [*6] |-> !output_enable; endproperty
  a_bias: assert property (p_bias)
    else $error("output on without bias");
endmodule

`default_nettype wire
